// file: ebsp_pkg.sv
// shared constants and types of the external bus stretch and port A block
package ebsp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indexes: byte address on the register bus is index times four
    localparam logic [7:0] IDX_PORT_A_PINS = 8'h00;
    localparam logic [7:0] IDX_PORT_A_DIR  = 8'h02;
    localparam logic [7:0] IDX_MISC        = 8'h13;
    localparam logic [7:0] IDX_CFG         = 8'h30;
    localparam logic [7:0] IDX_STAT        = 8'h31;

    // misc_mapping_control fields
    localparam int MISC_MAPROM    = 7;
    localparam int MISC_NARROW_RF = 6;
    localparam int MISC_RF_LSB    = 4;
    localparam int MISC_EX_LSB    = 2;
    localparam int MISC_FLASH_S   = 1;
    localparam int MISC_FLASH_L   = 0;

    // configuration and status fields
    localparam int CFG_MODE_LSB   = 0;
    localparam int CFG_EMU_E      = 2;
    localparam int CFG_BASE_LSB   = 8;
    localparam int STAT_BUSY      = 0;
    localparam int STAT_LEFT_LSB  = 1;
    localparam int STAT_MODE_LSB  = 3;
    localparam int STAT_PART      = 5;

    // reset values
    localparam logic [7:0] PORT_A_RST = 8'h00;
    localparam logic [7:0] DIR_RST    = 8'h00;
    localparam logic [7:0] MISC_RST   = 8'h0F;

    ////////////////////////////////////////////////////////////////////////
    // address map inside the 2K block chosen by the register base, then the flash array bounds
    localparam logic [1:0]  WIN_REG     = 2'h0;   // addr[10:9]: registers
    localparam logic [1:0]  WIN_RF      = 2'h1;   // addr[10:9]: following
    localparam logic [4:0]  REMOVED_TOP = 5'h00;  // addr[8:4]: first 16
    localparam logic [6:0]  PORT_AB_TOP = 7'h00;  // addr[8:2]: ports A, B
    localparam logic [7:0]  PORT_E_TOP  = 8'h04;  // addr[8:1]: port E pair
    localparam logic [15:0] FLASH_S_LO  = 16'h1000;
    localparam logic [15:0] FLASH_S_HI  = 16'h7FFF;
    localparam logic [15:0] FLASH_L_LO  = 16'h8000;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        MODE_SINGLE, MODE_EXP_NARROW, MODE_EXP_WIDE, MODE_PERIPH
    } ebsp_mode_t;

    typedef enum logic [2:0] {
        TGT_NONE, TGT_REG, TGT_RAM, TGT_FLASH_S, TGT_FLASH_L,
        TGT_RF, TGT_EXT, TGT_UNMAPPED
    } ebsp_tgt_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ADDR, ST_DATA} ebsp_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        word;
        logic        ram_hit;
    } ebsp_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        ebsp_tgt_t   target;
    } ebsp_rsp_t;

    typedef struct packed {
        logic [7:0]  pa_out;
        logic [7:0]  pa_oe;
        logic [7:0]  lo_out;
        logic [7:0]  lo_oe;
        logic        rw;
        logic        low_byte_strobe_n_n;
        logic [15:0] addr;
    } ebsp_bus_t;

endpackage

// file: ebsp_top.sv
// external bus control: stretch, access type strobes, port A multiplexing
// How it works
// (R1) following window stretched by its two-bit field
// (R2) following stretch ignores the narrow window bit
// (R3) external space stretched by its two-bit field
// (R4) no stretch in single-chip or peripheral mode
// (R5) flash enable bits map or unmap each array
// (R6) 16-bit inside, 8 or 16 outside, strobe sizes
// (R7) narrow window lets 8-bit parts share wide bus
// (R8) strobe and A0 both high only for RAM
// (R9) misaligned word: accessed byte on low half
// (R10) byte accesses coded by strobe, A0, read/write
// (R11) word accesses coded by strobe, A0, read/write
// (R12) peripheral mode removes the first sixteen registers
// (R13) expanded modes send port A/B registers outside
// (R14) emulate bit sends port E registers outside
// (R15) port A carries high address, high data, narrow data
// (R16) single-chip port A is general I/O, always accessible
// (R17) direction bit 0 input, 1 output
// (R18) following window after register block, moves with it
// (R19) narrow window uses port A only, 8-bit data
// (R20) address, strobe, read/write held through stretch
module ebsp_top
    import ebsp_pkg::*;
(
    input  wire logic        clk_i,                 // system clock
    input  wire logic        rst_i,                 // sync reset, high
    input  wire logic        psel_i,                // apb select
    input  wire logic        penable_i,             // apb enable
    input  wire logic        pwrite_i,              // apb write
    input  wire logic [7:0]  paddr_i,               // apb byte address
    input  wire logic [31:0] pwdata_i,              // apb write data
    output logic      [31:0] prdata_o,              // apb read data
    output logic             pready_o,              // apb ready
    output logic             pslverr_o,             // apb error
    input  wire logic        bus_e_clock_i,         // e clock from pin
    input  wire logic [7:0]  pa_in_i,               // port A pin levels
    input  wire logic [7:0]  lo_in_i,               // low lane pin levels
    input  wire logic        req_valid_i,           // core access request
    input  wire ebsp_req_t   req_i,                 // core access details
    output logic             req_ready_o,           // engine idle
    output logic             rsp_valid_o,           // access done pulse
    output ebsp_rsp_t        rsp_o,                 // read data, target
    output ebsp_bus_t        bus_o,                 // bus pin drive
    output logic             flash_small_enable_o,  // small array mapped
    output logic             flash_large_enable_o   // large array mapped
);

    ////////////////////////////////////////////////////////////////////////
    // module state
    typedef struct packed {
        logic        e_s1;
        logic        e_s2;
        logic        e_s3;
        logic        e_v;
        logic [7:0]  pa_s1;
        logic [7:0]  pa_s2;
        logic [7:0]  pa_s3;
        logic [7:0]  pa_v;
        logic [7:0]  lo_s1;
        logic [7:0]  lo_s2;
        logic [7:0]  lo_s3;
        logic [7:0]  lo_v;
        logic [7:0]  port_a_pins;
        logic [7:0]  port_a_direction;
        logic [7:0]  misc;
        ebsp_mode_t  mode;
        logic        emu_e;
        logic [4:0]  reg_base;
        ebsp_state_t st;
        ebsp_req_t   cur;
        ebsp_tgt_t   tgt;
        logic        narrow;
        logic        split;
        logic        part;
        logic [1:0]  str_set;
        logic [1:0]  str_left;
        logic [2:0]  falls;
        logic [15:0] rdata;
        logic        rsp_valid;
        ebsp_bus_t   bus;
    } ebsp_st_t;

    localparam int BUS_MAX = 200;

    ebsp_st_t    q;
    ebsp_st_t    d;
    logic        e_rise;
    logic        e_fall;
    logic        expanded;
    logic        apb_wr;
    logic [7:0]  widx;
    logic        hit_pa;
    logic        hit_dir;
    logic        hit_misc;
    logic        hit_cfg;
    logic        hit_stat;
    logic        apb_err;
    logic        in_reg;
    logic        in_rf;
    logic        ports_out;
    ebsp_tgt_t   tgt;
    logic        narrow;
    logic        split;
    logic        busc;
    logic [1:0]  str;
    logic [15:0] ca_q;
    logic [15:0] ca_d;
    logic        cword_d;
    logic [7:0]  bval;
    logic [7:0]  rbyte;

    ////////////////////////////////////////////////////////////////////////
    // address of the current byte or word cycle
    function automatic logic [15:0] cyc_addr(input ebsp_st_t s);
        cyc_addr = s.part ? s.cur.addr + 16'h0001 : s.cur.addr;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register bus decode
    assign widx     = {2'b00, paddr_i[7:2]};
    assign apb_wr   = psel_i & penable_i & pwrite_i & ~apb_err;
    assign hit_pa   = (paddr_i[1:0] == 2'b00) && (widx == IDX_PORT_A_PINS);
    assign hit_dir  = (paddr_i[1:0] == 2'b00) && (widx == IDX_PORT_A_DIR);
    assign hit_misc = (paddr_i[1:0] == 2'b00) && (widx == IDX_MISC);
    assign hit_cfg  = (paddr_i[1:0] == 2'b00) && (widx == IDX_CFG);
    assign hit_stat = (paddr_i[1:0] == 2'b00) && (widx == IDX_STAT);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & apb_err;

    // port A registers leave the map outside single-chip mode
    always_comb
    begin
        apb_err = 1'b0;
        if ((hit_pa || hit_dir) && q.mode != MODE_SINGLE)
            apb_err = 1'b1;  // see (R13)
        else if (!(hit_pa || hit_dir || hit_misc || hit_cfg || hit_stat))
            apb_err = 1'b1;
    end

    // read mux; port A reads pin level on inputs, latch on outputs
    always_comb
    begin
        prdata_o = 32'h0000_0000;
        if (apb_err)
            prdata_o = 32'h0000_0000;
        else if (hit_pa)
            prdata_o[7:0] = (q.port_a_direction & q.port_a_pins) | (~q.port_a_direction & q.pa_v);  // see (R16)
        else if (hit_dir)
            prdata_o[7:0] = q.port_a_direction;
        else if (hit_misc)
            prdata_o[7:0] = q.misc;
        else if (hit_cfg)
        begin
            prdata_o[CFG_MODE_LSB +: 2] = q.mode;
            prdata_o[CFG_EMU_E]         = q.emu_e;
            prdata_o[CFG_BASE_LSB +: 5] = q.reg_base;
        end
        else
        begin
            prdata_o[STAT_BUSY]          = (q.st != ST_IDLE);
            prdata_o[STAT_LEFT_LSB +: 2] = q.str_left;
            prdata_o[STAT_MODE_LSB +: 2] = q.mode;
            prdata_o[STAT_PART]          = q.part;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // e clock edges once the second and third stages agree
    assign e_rise = (q.e_s2 == q.e_s3) && q.e_s2 && !q.e_v;
    assign e_fall = (q.e_s2 == q.e_s3) && !q.e_s2 && q.e_v;
    assign expanded = (q.mode == MODE_EXP_NARROW) || (q.mode == MODE_EXP_WIDE);

    // target decode of a core request
    always_comb
    begin
        in_reg = (req_i.addr[15:11] == q.reg_base)
                 && (req_i.addr[10:9] == WIN_REG);
        in_rf  = (req_i.addr[15:11] == q.reg_base)
                 && (req_i.addr[10:9] == WIN_RF);  // see (R18)
        ports_out = expanded && ((req_i.addr[8:2] == PORT_AB_TOP)  // see (R13)
                    || (q.emu_e && req_i.addr[8:1] == PORT_E_TOP));  // see (R14)
        if (in_reg && q.mode == MODE_PERIPH
            && req_i.addr[8:4] == REMOVED_TOP)
            tgt = TGT_UNMAPPED;  // see (R12)
        else if (in_reg && ports_out)
            tgt = TGT_EXT;
        else if (in_reg)
            tgt = TGT_REG;
        else if (req_i.ram_hit)
            tgt = TGT_RAM;
        else if (q.misc[MISC_FLASH_S] && req_i.addr >= FLASH_S_LO
                 && req_i.addr <= FLASH_S_HI)
            tgt = TGT_FLASH_S;  // see (R5)
        else if (q.misc[MISC_FLASH_L] && req_i.addr >= FLASH_L_LO)
            tgt = TGT_FLASH_L;  // see (R5)
        else if (expanded && in_rf)
            tgt = TGT_RF;
        else if (expanded)
            tgt = TGT_EXT;
        else
            tgt = TGT_NONE;
        // narrow window only has meaning on the wide bus
        narrow = (q.mode == MODE_EXP_NARROW) || (q.mode == MODE_EXP_WIDE
                 && tgt == TGT_RF && q.misc[MISC_NARROW_RF]);  // see (R7) (R19)
        // words outside RAM go out as two byte cycles when narrow or odd
        split  = req_i.word && !req_i.ram_hit
                 && (narrow || req_i.addr[0]);  // see (R6) (R8)
        busc   = expanded && (tgt == TGT_RF || tgt == TGT_EXT
                 || tgt == TGT_RAM);
        if (!expanded)
            str = 2'd0;  // see (R4)
        else if (tgt == TGT_RF)
            str = q.misc[MISC_RF_LSB +: 2];  // see (R1) (R2)
        else if (tgt == TGT_EXT)
            str = q.misc[MISC_EX_LSB +: 2];  // see (R3)
        else
            str = 2'd0;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        d = q;
        d.rsp_valid = 1'b0;
        // three-stage pin synchronisers
        d.e_s1  = bus_e_clock_i;
        d.e_s2  = q.e_s1;
        d.e_s3  = q.e_s2;
        d.pa_s1 = pa_in_i;
        d.pa_s2 = q.pa_s1;
        d.pa_s3 = q.pa_s2;
        d.lo_s1 = lo_in_i;
        d.lo_s2 = q.lo_s1;
        d.lo_s3 = q.lo_s2;
        if (q.e_s2 == q.e_s3)
            d.e_v = q.e_s2;
        if (q.pa_s2 == q.pa_s3)
            d.pa_v = q.pa_s2;
        if (q.lo_s2 == q.lo_s3)
            d.lo_v = q.lo_s2;

        // register writes
        if (apb_wr)
        begin
            if (hit_pa)
                d.port_a_pins = pwdata_i[7:0];  // see (R16)
            else if (hit_dir)
                d.port_a_direction = pwdata_i[7:0];  // see (R16)
            else if (hit_misc)
                d.misc = pwdata_i[7:0];
            else if (hit_cfg)
            begin
                d.mode     = ebsp_mode_t'(pwdata_i[CFG_MODE_LSB +: 2]);
                d.emu_e    = pwdata_i[CFG_EMU_E];
                d.reg_base = pwdata_i[CFG_BASE_LSB +: 5];
            end
        end

        // bus cycle engine, paced by the sampled e clock
        ca_q = cyc_addr(q);
        rbyte = (q.narrow || !ca_q[0]) ? q.pa_v : q.lo_v;
        case (q.st)
            ST_IDLE:
                if (req_valid_i)
                begin
                    d.cur      = req_i;
                    d.tgt      = tgt;
                    d.narrow   = narrow;
                    d.split    = split;
                    d.part     = 1'b0;
                    d.str_set  = str;
                    d.str_left = str;
                    d.falls    = 3'd0;
                    d.rdata    = 16'h0000;
                    if (busc)
                        d.st = ST_WAIT;
                    else
                        d.rsp_valid = 1'b1;
                end
            ST_WAIT:
                if (e_fall)
                    d.st = ST_ADDR;
            ST_ADDR:
                if (e_rise)
                    d.st = ST_DATA;
            ST_DATA:
                if (e_fall)
                begin
                    d.falls = q.falls + 3'd1;
                    if (q.str_left != 2'd0)
                        d.str_left = q.str_left - 2'd1;  // see (R1) (R3) (R20)
                    else
                    begin
                        if (q.split)
                        begin
                            if (q.part)
                                d.rdata[7:0] = rbyte;
                            else
                                d.rdata[15:8] = rbyte;
                        end
                        else if (q.cur.word && ca_q[0])
                            d.rdata = {q.lo_v, q.pa_v};  // see (R9)
                        else if (q.cur.word)
                            d.rdata = {q.pa_v, q.lo_v};
                        else
                            d.rdata = {8'h00, rbyte};
                        if (q.split && !q.part)
                        begin
                            d.part     = 1'b1;
                            d.str_left = q.str_set;
                            d.falls    = 3'd0;
                            d.st       = ST_ADDR;
                        end
                        else
                        begin
                            d.st        = ST_IDLE;
                            d.rsp_valid = 1'b1;
                        end
                    end
                end
            default:
                d.st = ST_IDLE;
        endcase

        // pin drive, registered alongside the state it belongs to
        ca_d    = cyc_addr(d);
        cword_d = d.cur.word && !d.split;
        bval    = (d.split && !d.part) ? d.cur.wdata[15:8] : d.cur.wdata[7:0];
        d.bus.pa_out  = d.port_a_pins;  // see (R16)
        d.bus.pa_oe   = d.port_a_direction;  // see (R17)
        d.bus.lo_out  = 8'h00;
        d.bus.lo_oe   = 8'h00;
        d.bus.rw      = 1'b1;
        d.bus.low_byte_strobe_n_n = 1'b1;
        d.bus.addr    = 16'h0000;
        if (d.mode != MODE_SINGLE)
        begin
            d.bus.pa_out = 8'h00;
            d.bus.pa_oe  = 8'h00;
        end
        if (d.mode != MODE_SINGLE && (d.st == ST_ADDR || d.st == ST_DATA))
        begin
            // strobe and A0 together code the size and alignment
            d.bus.low_byte_strobe_n_n = cword_d ? ca_d[0] : ~ca_d[0];  // see (R10) (R11)
            d.bus.rw      = ~d.cur.write;
            d.bus.addr    = ca_d;
            d.bus.lo_out  = ca_d[7:0];
            d.bus.lo_oe   = 8'hFF;
            if (d.st == ST_ADDR)
            begin
                d.bus.pa_out = ca_d[15:8];  // see (R15)
                d.bus.pa_oe  = 8'hFF;
            end
            else if (d.narrow)
            begin
                d.bus.pa_out = bval;  // see (R15) (R19)
                d.bus.pa_oe  = {8{d.cur.write}};
            end
            else if (cword_d && ca_d[0])
            begin
                d.bus.pa_out = d.cur.wdata[7:0];  // see (R9)
                d.bus.lo_out = d.cur.wdata[15:8];
                d.bus.pa_oe  = {8{d.cur.write}};
                d.bus.lo_oe  = {8{d.cur.write}};
            end
            else if (cword_d)
            begin
                d.bus.pa_out = d.cur.wdata[15:8];  // see (R6)
                d.bus.lo_out = d.cur.wdata[7:0];
                d.bus.pa_oe  = {8{d.cur.write}};
                d.bus.lo_oe  = {8{d.cur.write}};
            end
            else if (ca_d[0])
            begin
                d.bus.lo_out = bval;
                d.bus.lo_oe  = {8{d.cur.write}};
            end
            else
            begin
                d.bus.pa_out = bval;
                d.bus.pa_oe  = {8{d.cur.write}};
                d.bus.lo_oe  = 8'h00;
            end
        end

        // synchronous reset
        if (rst_i)
        begin
            d         = '0;
            d.port_a_pins   = PORT_A_RST;
            d.port_a_direction    = DIR_RST;
            d.misc    = MISC_RST;
            d.bus.rw  = 1'b1;
            d.bus.low_byte_strobe_n_n = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign req_ready_o          = (q.st == ST_IDLE);
    assign rsp_valid_o          = q.rsp_valid;
    assign rsp_o                = '{rdata: q.rdata, target: q.tgt};
    assign bus_o                = q.bus;
    assign flash_small_enable_o = q.misc[MISC_FLASH_S];
    assign flash_large_enable_o = q.misc[MISC_FLASH_L];

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_STRETCH_COUNT: assert property (  // see (R1) (R3)
        q.st == ST_DATA && e_fall && q.str_left == 2'd0
        |-> q.falls == {1'b0, q.str_set})
        else $error("stretch length differs from setting");
    AST_RF_FIELD: assert property (  // see (R1) (R2)
        req_valid_i && req_ready_o && tgt == TGT_RF
        |=> q.str_set == $past(q.misc[MISC_RF_LSB +: 2]))
        else $error("following window stretch not taken from field");
    AST_NO_BUS_SINGLE: assert property (  // see (R4)
        req_valid_i && req_ready_o && q.mode == MODE_SINGLE
        |=> rsp_valid_o && q.st == ST_IDLE)
        else $error("single-chip access did not finish at once");
    AST_FLASH_L: assert property (  // see (R5)
        req_valid_i && req_ready_o && !in_reg && !req_i.ram_hit
        && req_i.addr[15] && q.misc[MISC_FLASH_L]
        |=> rsp_valid_o && rsp_o.target == TGT_FLASH_L)
        else $error("enabled large flash not selected");
    AST_RAM_ONLY_SWAP: assert property (  // see (R8)
        q.st == ST_DATA && q.bus.low_byte_strobe_n_n && q.bus.addr[0]
        |-> q.cur.ram_hit)
        else $error("swapped word strobe code outside RAM");
    AST_SWAP_LANES: assert property (  // see (R9)
        q.st == ST_DATA && q.bus.low_byte_strobe_n_n && q.bus.addr[0] && q.cur.write
        |-> q.bus.lo_out == q.cur.wdata[15:8]
            && q.bus.pa_out == q.cur.wdata[7:0])
        else $error("misaligned word lanes not swapped");
    AST_BYTE_CODE: assert property (  // see (R10)
        q.st == ST_DATA && (!q.cur.word || q.split)
        |-> q.bus.low_byte_strobe_n_n != q.bus.addr[0])
        else $error("byte cycle strobe code wrong");
    AST_HOLD: assert property (  // see (R20)
        q.st == ST_DATA && $past(q.st) == ST_DATA
        |-> $stable(q.bus.addr) && $stable(q.bus.low_byte_strobe_n_n)
            && $stable(q.bus.rw))
        else $error("bus cycle outputs moved during stretch");
    AST_PERIPH_REMOVED: assert property (  // see (R12)
        req_valid_i && req_ready_o && q.mode == MODE_PERIPH && in_reg
        && req_i.addr[8:4] == REMOVED_TOP
        |=> rsp_o.target == TGT_UNMAPPED)
        else $error("peripheral mode kept a removed register");
    AST_PORTS_EXT: assert property (  // see (R13) (R14)
        req_valid_i && req_ready_o && in_reg && ports_out
        |=> rsp_o.target == TGT_EXT ##[0:BUS_MAX] rsp_valid_o)
        else $error("port register access not sent outside");
    AST_GPIO_DIR: assert property (  // see (R16) (R17)
        apb_wr && hit_dir && q.mode == MODE_SINGLE
        |=> ##1 q.bus.pa_oe == $past(pwdata_i[7:0], 2))
        else $error("port A direction not applied to pins");
    AST_NARROW_LANE: assert property (  // see (R19)
        q.st == ST_DATA && q.narrow |-> q.bus.lo_out == q.bus.addr[7:0])
        else $error("narrow cycle used the low lane for data");

    COV_SPLIT: cover property (q.st == ST_DATA && q.split && q.part
        && rsp_valid_o == 1'b0 ##[1:BUS_MAX] rsp_valid_o);
    COV_RF_STRETCH: cover property (q.tgt == TGT_RF && q.str_set == 2'd3
        && q.st == ST_DATA && e_fall && q.str_left == 2'd0);
    COV_RAM_SWAP: cover property (q.st == ST_DATA && q.bus.low_byte_strobe_n_n
        && q.bus.addr[0] && q.cur.word);

endmodule

// file: ebsp_partner.sv
// far side model: e clock source and external pins answering the lanes
module ebsp_partner
    import ebsp_pkg::*;
(
    input  wire ebsp_bus_t  bus_i,  // lanes driven by the block
    output logic            e_o,    // free running e clock
    output logic [7:0]      pa_o,   // port A pin levels
    output logic [7:0]      lo_o    // low lane pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // e clock, its edges land on falling edges of the system clock
    initial e_o = 1'b0;
    always #80 e_o = ~e_o;
    // released lanes show the memory's data, driven lanes echo back
    assign pa_o = (bus_i.pa_oe == 8'hFF) ? bus_i.pa_out : 8'hA5;
    assign lo_o = (bus_i.lo_oe == 8'hFF) ? bus_i.lo_out : 8'h5A;
endmodule

// file: tb.sv
// self-checking bench of the bus stretch and port A block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ebsp_pkg::*;
    typedef struct packed
    {
        logic w; logic [7:0] a; logic [7:0] d; logic [7:0] r; logic e;
    } ebsp_row_t;
    logic clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, rv = 0;
    logic [7:0] paddr = 0, pa, lo;
    logic [31:0] pwd = 0, prd, r;
    logic rdy, err, e, rq_rdy, rsp_v, fs, fl, k;
    ebsp_req_t req = '0;
    ebsp_rsp_t rsp;
    ebsp_bus_t bus;
    int n_fail = 0, check_count = 0, n;
    ebsp_row_t rows [8] = '{
        '{0, 8'h4C, 8'h00, 8'h0F, 0}, '{0, 8'h08, 8'h00, 8'h00, 0},
        '{0, 8'h00, 8'h00, 8'hA5, 0}, '{1, 8'h08, 8'hFF, 8'h00, 0},
        '{0, 8'h08, 8'h00, 8'hFF, 0}, '{1, 8'h00, 8'h3C, 8'h00, 0},
        '{0, 8'h00, 8'h00, 8'h3C, 0}, '{0, 8'h04, 8'h00, 8'h00, 1}};
    always #5 clk_i = ~clk_i;
    ebsp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
        .bus_e_clock_i(e), .pa_in_i(pa), .lo_in_i(lo), .req_valid_i(rv),
        .req_i(req), .req_ready_o(rq_rdy), .rsp_valid_o(rsp_v),
        .rsp_o(rsp), .bus_o(bus), .flash_small_enable_o(fs),
        .flash_large_enable_o(fl));
    ebsp_partner u_far (.bus_i(bus), .e_o(e), .pa_o(pa), .lo_o(lo));
    ////////////////////////////////////////////////////////////////////
    // compare, verdict and bus tasks
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task results;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk_i) pen <= 1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            if (rdy === 1'b1) break;
        end
        if (i == 20) begin n_fail++; results(); end
        r = prd;
        k = err;
        psel <= 0; pen <= 0;
        @(posedge clk_i);
    endtask
    // byte write on the core side, counting cycles that show a write
    task bw(input logic [15:0] a);
        int i;
        n = 0;
        rv <= 1; req <= '{a, 16'h00C3, 1'b1, 1'b0, 1'b0};
        @(posedge clk_i) rv <= 0;
        for (i = 0; i < 400 && rsp_v !== 1'b1; i++)
        begin
            @(posedge clk_i);
            if (bus.rw === 1'b0) n++;
            if (bus.rw === 1'b0)
                chk({bus.low_byte_strobe_n_n, bus.addr[0], rq_rdy}, 3'b100);
        end
        if (i == 400) begin n_fail++; results(); end
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence: reset, table rows, then stretch cases
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        repeat (4) @(posedge clk_i);
        foreach (rows[j])
        begin
            apb(rows[j].w, rows[j].a, {24'h0, rows[j].d});
            if (!rows[j].w) chk(r, {24'h0, rows[j].r});
            chk(k, rows[j].e);
        end
        chk({bus.pa_oe, bus.pa_out}, 16'hFF3C);
        bw(16'h8000);
        chk(rsp.target, TGT_FLASH_L);
        chk(n, 0);
        apb(1, 8'h4C, 32'h0000_0002);
        chk({fs, fl}, 2'b10);
        bw(16'h8000);
        chk(rsp.target, TGT_NONE);
        apb(1, 8'hC0, 32'h0000_0003);
        bw(16'h0000);
        chk(rsp.target, TGT_UNMAPPED);
        chk(n, 0);
        $display("register rows done");
        apb(1, 8'hC0, 32'h0000_0002);
        apb(0, 8'h00, 32'h0000_0000);
        chk(k, 1);
        for (int s = 0; s < 4; s++)
        begin
            apb(1, 8'h4C, {24'h0, 2'b00, s[1:0], s[1:0], 2'b00});
            bw(16'h2000);
            chk(n >= 16 * s + 14 && n <= 16 * s + 18, 1);
            bw(16'h0200);
            chk(n >= 16 * s + 14 && n <= 16 * s + 18, 1);
        end
        bw(16'h0002);
        chk(rsp.target, TGT_EXT);
        $display("stretch cases done");
        // reset in mid-run brings back single-chip values
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        repeat (4) @(posedge clk_i);
        apb(0, 8'h4C, 32'h0000_0000);
        chk(r, 32'h0000_000F);
        apb(0, 8'h00, 32'h0000_0000);
        chk(r, 32'h0000_00A5);
        chk(k, 0);
        $display("reset case done");
        results();
    end
endmodule
